//--- rtl/cs_core_sfr.sv
// Core special-function register block with two indirect data-memory pointers
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

module cs_core_sfr
    import cs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,

    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,

    // Hardware status events, one-cycle pulses from the core
    input  wire logic [7:0]  reset_cause_set_i,
    input  wire logic        mem_violation_set_i,

    // Register views for the execution core
    output logic      [13:0] pointer_zero_o,
    output logic      [13:0] pointer_one_o,
    output logic      [7:0]  working_accumulator_o,
    output logic      [7:0]  bank_select_o
);

    // Bus decode
    logic                    ack_r;
    logic [31:0]             dat_r;
    logic                    req;
    logic                    mapped;
    logic [CS_IDX_W-1:0]     idx;
    logic                    wr_en;
    logic                    rd_en;

    // Pointers and their ports
    logic [13:0]             ptr_r       [2];
    logic [13:0]             ptr_nxt     [2];
    logic [13:0]             eff_addr    [2];
    cs_access_e              acc_kind    [2];
    logic [1:0]              ptr_hit;

    // Storage
    logic [7:0]              plain_r     [CS_NUM_PLAIN];
    logic [CS_NUM_PLAIN-1:0] plain_hit;
    logic [7:0]              reset_cause_r;
    logic [7:0]              mem_violation_r;
    logic [7:0]              mem         [CS_MEM_DEPTH];

    // Memory access path
    logic                    ind_hit;
    logic                    direct_hit;
    logic [13:0]             mem_addr;
    logic [7:0]              mem_rdata;
    logic [7:0]              rd_data;
    logic [13:0]             w_offset;

    assign req    = wb_cyc_i && wb_stb_i && !ack_r;
    assign mapped = (wb_adr_i[31:16] == 16'h0000);
    assign idx    = wb_adr_i[15:2];
    // Only byte lane 0 carries a register; other lanes are ignored
    assign wr_en  = req && mapped && wb_we_i && wb_sel_i[0];
    assign rd_en  = req && mapped && !wb_we_i;

    // The working register is taken as a signed offset, so indexed access reaches
    // both sides of the pointer
    assign w_offset = {{6{plain_r[CS_SLOT_WACC][7]}}, plain_r[CS_SLOT_WACC]};

    // Pointer logic, one copy per pointer
    generate
        for (genvar p = 0; p < 2; p++)
        begin : g_ptr
            always_comb
            begin
                if (idx == CS_PLAIN_IDX[p])
                begin
                    acc_kind[p] = CS_ACC_PLAIN;
                end
                else if (idx == CS_POSTINC_IDX[p])
                begin
                    acc_kind[p] = CS_ACC_POSTINC;
                end
                else if (idx == CS_POSTDEC_IDX[p])
                begin
                    acc_kind[p] = CS_ACC_POSTDEC;
                end
                else if (idx == CS_PREINC_IDX[p])
                begin
                    acc_kind[p] = CS_ACC_PREINC;
                end
                else if (idx == CS_INDEXED_IDX[p])
                begin
                    acc_kind[p] = CS_ACC_INDEXED;
                end
                else
                begin
                    acc_kind[p] = CS_ACC_NONE;
                end
            end

            assign ptr_hit[p] = (acc_kind[p] != CS_ACC_NONE) && mapped;

            // Address used by this access
            always_comb
            begin
                unique case (acc_kind[p])
                    CS_ACC_PREINC:  eff_addr[p] = ptr_r[p] + CS_PTR_ONE;
                    CS_ACC_INDEXED: eff_addr[p] = ptr_r[p] + w_offset;
                    CS_ACC_NONE:    eff_addr[p] = ptr_r[p];
                    default:        eff_addr[p] = ptr_r[p];
                endcase
            end

            // Pointer value after this access; a full 14-bit add carries
            // between the two bytes in the same cycle
            always_comb
            begin
                ptr_nxt[p] = ptr_r[p];
                if (req && mapped && (wb_we_i ? wb_sel_i[0] : 1'b1))
                begin
                    unique case (acc_kind[p])
                        CS_ACC_POSTINC: ptr_nxt[p] = ptr_r[p] + CS_PTR_ONE;
                        CS_ACC_POSTDEC: ptr_nxt[p] = ptr_r[p] - CS_PTR_ONE;
                        CS_ACC_PREINC:  ptr_nxt[p] = ptr_r[p] + CS_PTR_ONE;
                        CS_ACC_PLAIN:   ptr_nxt[p] = ptr_r[p];
                        CS_ACC_INDEXED: ptr_nxt[p] = ptr_r[p];
                        CS_ACC_NONE:    ptr_nxt[p] = ptr_r[p];
                    endcase
                end
                if (wr_en && idx == CS_PTR_LOW_IDX[p])
                begin
                    ptr_nxt[p] = {ptr_r[p][13:8], wb_dat_i[7:0]};
                end
                if (wr_en && idx == CS_PTR_HIGH_IDX[p])
                begin
                    ptr_nxt[p] = {wb_dat_i[5:0], ptr_r[p][7:0]};
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    ptr_r[p] <= CS_PTR_RST;
                end
                else
                begin
                    ptr_r[p] <= ptr_nxt[p];
                end
            end
        end
    endgenerate

    // Plain storage registers, unimplemented bits held at zero
    generate
        for (genvar r = 0; r < CS_NUM_PLAIN; r++)
        begin : g_plain
            assign plain_hit[r] = mapped && (idx == CS_PLAIN_REG_IDX[r]);

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    plain_r[r] <= CS_REG_RST;
                end
                else if (wr_en && plain_hit[r])
                begin
                    plain_r[r] <= wb_dat_i[7:0] & CS_PLAIN_REG_MASK[r];
                end
            end
        end
    endgenerate

    // Status flags: hardware sets, software writes; a set in the same cycle as a
    // clearing write wins so that no event is lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reset_cause_r <= CS_REG_RST;
        end
        else if (wr_en && idx == CS_RESET_CAUSE)
        begin
            reset_cause_r <= (wb_dat_i[7:0] | reset_cause_set_i) & CS_RESET_CAUSE_MASK;
        end
        else
        begin
            reset_cause_r <= (reset_cause_r | reset_cause_set_i) & CS_RESET_CAUSE_MASK;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_violation_r <= CS_REG_RST;
        end
        else if (wr_en && idx == CS_MEM_VIOLATION)
        begin
            mem_violation_r <= (wb_dat_i[7:0] | {1'b0, mem_violation_set_i, 6'h00}) & CS_VIOL_MASK;
        end
        else if (mem_violation_set_i)
        begin
            mem_violation_r <= mem_violation_r | CS_VIOL_MASK;
        end
    end

    // Data memory: direct below the register area, indirect through the ports.
    // Indirect accesses always land in the array, even when the pointer names
    // the register area, which keeps one write path into the memory.
    assign ind_hit    = |ptr_hit;
    assign direct_hit = mapped && (idx < CS_SFR_BASE);

    always_comb
    begin
        if (ptr_hit[0])
        begin
            mem_addr = eff_addr[0];
        end
        else if (ptr_hit[1])
        begin
            mem_addr = eff_addr[1];
        end
        else
        begin
            mem_addr = idx;
        end
    end

    assign mem_rdata = mem[mem_addr];

    always_ff @(posedge clk_i)
    begin
        if (wr_en && (ind_hit || direct_hit))
        begin
            mem[mem_addr] <= wb_dat_i[7:0];
        end
    end

    // Read mux
    always_comb
    begin
        rd_data = 8'h00;
        if (ind_hit || direct_hit)
        begin
            rd_data = mem_rdata;
        end
        else if (idx == CS_PTR0_LOW)
        begin
            rd_data = ptr_r[0][7:0];
        end
        else if (idx == CS_PTR0_HIGH)
        begin
            rd_data = {2'b00, ptr_r[0][13:8]} & CS_PTR_HIGH_MASK;
        end
        else if (idx == CS_PTR1_LOW)
        begin
            rd_data = ptr_r[1][7:0];
        end
        else if (idx == CS_PTR1_HIGH)
        begin
            rd_data = {2'b00, ptr_r[1][13:8]} & CS_PTR_HIGH_MASK;
        end
        else if (idx == CS_RESET_CAUSE)
        begin
            rd_data = reset_cause_r;
        end
        else if (idx == CS_MEM_VIOLATION)
        begin
            rd_data = mem_violation_r;
        end
        else
        begin
            for (int i = 0; i < CS_NUM_PLAIN; i++)
            begin
                if (plain_hit[i])
                begin
                    rd_data = plain_r[i];
                end
            end
        end
    end

    // Bus answer: one wait state, ack for exactly one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= req;
        end
    end

    // Unmapped and write cycles answer with zero data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_r <= 32'h0000_0000;
        end
        else if (req)
        begin
            dat_r <= rd_en ? {24'h00_0000, rd_data} : 32'h0000_0000;
        end
    end

    // Core-facing views, registered; the pointer views take the next value so
    // they move on the same edge as the pointers, with no extra lag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pointer_zero_o <= CS_PTR_RST;
        end
        else
        begin
            pointer_zero_o <= ptr_nxt[0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pointer_one_o <= CS_PTR_RST;
        end
        else
        begin
            pointer_one_o <= ptr_nxt[1];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            working_accumulator_o <= CS_REG_RST;
        end
        else
        begin
            working_accumulator_o <= plain_r[CS_SLOT_WACC];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bank_select_o <= CS_REG_RST;
        end
        else
        begin
            bank_select_o <= plain_r[CS_SLOT_BANK];
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule // cs_core_sfr

//--- include/cs_pkg.sv
// Constants and types shared by the core special-function register block
package cs_pkg;

    // Register indices; the bus byte address is four times the index
    localparam int unsigned CS_IDX_W          = 14;
    localparam logic [13:0] CS_SFR_BASE       = 14'h3fe0;
    localparam logic [13:0] CS_PTR1_LOW       = 14'h3fe1;
    localparam logic [13:0] CS_PTR1_HIGH      = 14'h3fe2;
    localparam logic [13:0] CS_PTR0_LOW       = 14'h3fe9;
    localparam logic [13:0] CS_PTR0_HIGH      = 14'h3fea;
    localparam logic [13:0] CS_RESET_CAUSE    = 14'h3ff0;
    localparam logic [13:0] CS_MEM_VIOLATION  = 14'h3ff1;

    // Indirect ports, entry 0 for pointer_zero and entry 1 for pointer_one
    localparam logic [13:0] CS_PLAIN_IDX   [2] = '{14'h3fef, 14'h3fe7};
    localparam logic [13:0] CS_POSTINC_IDX [2] = '{14'h3fee, 14'h3fe6};
    localparam logic [13:0] CS_POSTDEC_IDX [2] = '{14'h3fed, 14'h3fe5};
    localparam logic [13:0] CS_PREINC_IDX  [2] = '{14'h3fec, 14'h3fe4};
    localparam logic [13:0] CS_INDEXED_IDX [2] = '{14'h3feb, 14'h3fe3};
    localparam logic [13:0] CS_PTR_LOW_IDX [2] = '{CS_PTR0_LOW, CS_PTR1_LOW};
    localparam logic [13:0] CS_PTR_HIGH_IDX[2] = '{CS_PTR0_HIGH, CS_PTR1_HIGH};

    // Plain storage registers: bank_select, working_accumulator, product_low/high,
    // table_latch, table_ptr_low/high/upper, program_counter_low, pc_high/upper_holding,
    // stack_depth_pointer, stack_top_low/high/upper
    localparam int unsigned CS_NUM_PLAIN = 15;
    localparam logic [13:0] CS_PLAIN_REG_IDX [CS_NUM_PLAIN] = '{
        14'h3fe0, 14'h3fe8, 14'h3ff3, 14'h3ff4, 14'h3ff5, 14'h3ff6, 14'h3ff7, 14'h3ff8,
        14'h3ff9, 14'h3ffa, 14'h3ffb, 14'h3ffc, 14'h3ffd, 14'h3ffe, 14'h3fff};
    localparam logic [7:0]  CS_PLAIN_REG_MASK [CS_NUM_PLAIN] = '{
        8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
        8'hff, 8'hff, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'h1f};
    localparam int unsigned CS_SLOT_BANK = 0;
    localparam int unsigned CS_SLOT_WACC = 1;

    // Field layouts
    localparam logic [7:0]  CS_PTR_HIGH_MASK  = 8'h3f;
    localparam logic [7:0]  CS_RESET_CAUSE_MASK = 8'hff;
    localparam logic [7:0]  CS_VIOL_MASK      = 8'h40;

    // Reset values
    localparam logic [7:0]  CS_REG_RST        = 8'h00;
    localparam logic [13:0] CS_PTR_RST        = 14'h0000;

    // Data memory
    localparam int unsigned CS_MEM_DEPTH      = 16384;
    localparam logic [13:0] CS_PTR_ONE        = 14'h0001;

    // Kind of indirect access
    typedef enum logic [2:0] {
        CS_ACC_NONE,
        CS_ACC_PLAIN,
        CS_ACC_POSTINC,
        CS_ACC_POSTDEC,
        CS_ACC_PREINC,
        CS_ACC_INDEXED
    } cs_access_e;

endpackage

//--- tb/cs_core_model.sv
// Execution core stand-in that raises status event pulses
`timescale 1ns/1ps

module cs_core_model
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench request, one bit per event
    input  wire logic [8:0] fire_i,
    // Event pulses toward the block
    output logic      [7:0] cause_o,
    output logic            viol_o
);
    // Registered, so each event starts one edge later and lasts as long as its fire_i bit
    always_ff @(posedge clk_i)
    begin
        {viol_o, cause_o} <= rst_i ? 9'h000 : fire_i;
    end
endmodule // cs_core_model

//--- tb/cs_core_sfr_chk.sv
// Bus and pointer-step assertions for the special-function register block
`timescale 1ns/1ps

module cs_core_sfr_chk
    import cs_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone slave side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Status events
    input wire logic [7:0]  reset_cause_set_i,
    input wire logic        mem_violation_set_i,
    // Register views
    input wire logic [13:0] pointer_zero_o,
    input wire logic [13:0] pointer_one_o,
    input wire logic [7:0]  working_accumulator_o,
    input wire logic [7:0]  bank_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    sequence step_s(logic [13:0] idx);
        take && wb_adr_i == {16'h0000, idx, 2'b00} && (!wb_we_i || wb_sel_i[0]);
    endsequence
    ack_after_take_a: assert property (take |=> wb_ack_o) else $error("ack late");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
    plain_hold_a: assert property (step_s(CS_PLAIN_IDX[0]) |=> $stable(pointer_zero_o))
        else $error("plain port moved pointer");
    postinc_step_a: assert property (step_s(CS_POSTINC_IDX[0])
        |=> pointer_zero_o == $past(pointer_zero_o) + CS_PTR_ONE) else $error("postinc step");
    postdec_step_a: assert property (step_s(CS_POSTDEC_IDX[1])
        |=> pointer_one_o == $past(pointer_one_o) - CS_PTR_ONE) else $error("postdec step");
    preinc_step_a: assert property (step_s(CS_PREINC_IDX[1])
        |=> pointer_one_o == $past(pointer_one_o) + CS_PTR_ONE) else $error("preinc step");
    indexed_hold_a: assert property (step_s(CS_INDEXED_IDX[0]) |=> $stable(pointer_zero_o))
        else $error("indexed port moved pointer");
endmodule // cs_core_sfr_chk

bind cs_core_sfr cs_core_sfr_chk u_chk (.*);

//--- tb/cs_core_sfr_indirect_addressing_test.sv
// Self-checking bench for the special-function register block
`timescale 1ns/1ps

module cs_core_sfr_indirect_addressing_test;
    import cs_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [31:0] adr = 0, dat = 0, rd;
    logic [8:0] fire = 0;
    logic [7:0] cause, m [int], wm = 0;
    logic viol, ack;
    logic [3:0] sel = 4'h1, lane = 4'h1;
    logic [13:0] p0, p1, pm [2];
    logic [7:0] wacc_o, bank_o, q [$];
    logic [31:0] rnd = 32'hb7f788b9;
    int error_cnt = 0, n_compared = 0, cyc_cnt = 0;

    cs_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .cause_o(cause), .viol_o(viol));
    cs_core_sfr dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .reset_cause_set_i(cause), .mem_violation_set_i(viol), .pointer_zero_o(p0),
        .pointer_one_o(p1), .working_accumulator_o(wacc_o), .bank_select_o(bank_o));

    initial forever #2.5 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ad(input logic [13:0] i);
        return {16'h0000, i, 2'b00};
    endfunction
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
        sel <= lane;
        if (!w) q.push_back(e);
        do @(posedge clk_i); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic setp(input int p, input logic [13:0] v);
        bus(1, ad(CS_PTR_LOW_IDX[p]), v[7:0], 0);
        bus(1, ad(CS_PTR_HIGH_IDX[p]), {2'b11, v[13:8]}, 0);
        bus(0, ad(CS_PTR_HIGH_IDX[p]), 0, {2'b00, v[13:8]});
        pm[p] = v;
    endtask
    task automatic acc(input int p, input cs_access_e k, input logic w, input logic [7:0] d);
        logic [13:0] ea, i;
        ea = k == CS_ACC_PREINC ? pm[p] + 14'h1 : pm[p];
        if (k == CS_ACC_INDEXED) ea = pm[p] + {{6{wm[7]}}, wm};
        case (k)
            CS_ACC_PLAIN: i = CS_PLAIN_IDX[p];
            CS_ACC_POSTINC: i = CS_POSTINC_IDX[p];
            CS_ACC_POSTDEC: i = CS_POSTDEC_IDX[p];
            CS_ACC_PREINC: i = CS_PREINC_IDX[p];
            default: i = CS_INDEXED_IDX[p];
        endcase
        if (!m.exists(ea)) w = 1;
        if (w) m[ea] = d;
        bus(w, ad(i), d, m[ea]);
        if (k == CS_ACC_POSTINC || k == CS_ACC_PREINC) pm[p] = pm[p] + 14'h1;
        if (k == CS_ACC_POSTDEC) pm[p] = pm[p] - 14'h1;
        chk("pointer", pm[p], p ? p1 : p0);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Read data is judged against the oldest note left by the driver
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
            chk("read data", {6'h0, q.pop_front()}, {6'h0, rd[7:0]});
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < CS_NUM_PLAIN; i++)
        begin
            bus(0, ad(CS_PLAIN_REG_IDX[i]), 0, 8'h00);
            bus(1, ad(CS_PLAIN_REG_IDX[i]), 8'hff, 0);
            bus(0, ad(CS_PLAIN_REG_IDX[i]), 0, CS_PLAIN_REG_MASK[i]);
        end
        wm = 8'hff;
        chk("bank view", 14'h3f, bank_o);
        chk("working view", 14'hff, wacc_o);
        bus(1, 32'h0001_0000 | ad(CS_PLAIN_REG_IDX[1]), 8'h12, 0);
        bus(0, ad(CS_PLAIN_REG_IDX[1]), 0, 8'hff);
        bus(0, ad(14'h3ff2), 0, 8'h00);
        $display("registers and unmapped done");
        @(posedge clk_i) fire <= 9'h181;
        @(posedge clk_i) fire <= 9'h000;
        bus(0, ad(CS_RESET_CAUSE), 0, 8'h81);
        bus(0, ad(CS_MEM_VIOLATION), 0, CS_VIOL_MASK);
        bus(1, ad(CS_RESET_CAUSE), 8'h00, 0);
        bus(0, ad(CS_RESET_CAUSE), 0, 8'h00);
        $display("status flags done");
        bus(1, ad(14'h0100), 8'h5a, 0);
        m[14'h0100] = 8'h5a;
        for (int p = 0; p < 2; p++)
        begin
            setp(p, 14'h3fff);
            acc(p, CS_ACC_POSTINC, 1, 8'ha5);
            acc(p, CS_ACC_POSTDEC, 1, 8'h3c);
            acc(p, CS_ACC_PLAIN, 0, 0);
            setp(p, 14'h00ff);
            acc(p, CS_ACC_PREINC, 0, 0);
            acc(p, CS_ACC_INDEXED, 0, 0);
        end
        // A write without byte lane 0 must neither store nor step the pointer
        lane = 4'he;
        bus(1, ad(CS_POSTINC_IDX[0]), 8'h77, 0);
        lane = 4'h1;
        chk("masked write pointer", pm[0], p0);
        acc(0, CS_ACC_PLAIN, 0, 0);
        $display("pointer boundaries done");
        for (int n = 0; n < 300; n++)
        begin
            rnd = lfsr(rnd);
            if (rnd[10:8] == 3'h0)
            begin
                wm = rnd[23:16];
                bus(1, ad(CS_PLAIN_REG_IDX[CS_SLOT_WACC]), wm, 0);
            end
            acc(rnd[0], cs_access_e'(rnd[7:4] % 5 + 1), rnd[1], rnd[31:24]);
        end
        chk("working view", {6'h0, wm}, {6'h0, wacc_o});
        $display("random accesses done");
        end_of_test();
    end
endmodule // cs_core_sfr_indirect_addressing_test
